// ---- rtl/btc_splitter.sv ----
// serial input, sample fifo and two's complement splitter
`timescale 1ns/1ps
`include "splitter_regs.svh"

module sample_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] fill;
  logic push, pop;

  assign fill = wr_q - rd_q;

  assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  property p_fifo_bound;
    @(posedge ref_clk) disable iff (sys_rst)
    fill <= DEPTH;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) // [RULE8]
    else $error("sample fifo overfilled");
endmodule

module btc_splitter (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic serial_data,
  input wire logic bit_clock,
  input wire logic word_latch_strobe,
  output logic word_accept_ready,
  output splitter_pkg::lower_code_type lower_code,
  output splitter_pkg::upper_code_type upper_code,
  output logic code_update
);
  import splitter_pkg::*;

  // two-stage synchronisers for the three pins
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic data_s, clk_s, strobe_s;
  logic clk_rise, strobe_fall;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= {serial_data, bit_clock, word_latch_strobe};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign data_s = pin_s2_q[2];
  assign clk_s = pin_s2_q[1];
  assign strobe_s = pin_s2_q[0];
  assign clk_rise = clk_s && !pin_s3_q[1];
  assign strobe_fall = !strobe_s && pin_s3_q[0];

  // serial shift register, newest bit at the bottom
  sample_type shift_q, shift_d;

  always_comb begin
    shift_d = shift_q;
    if (clk_rise) begin
      shift_d = {shift_q[`SPL_WORD_BITS-2:0], data_s}; // [RULE7]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shift_q <= '0;
    end else begin
      shift_q <= shift_d;
    end
  end

  // latched words wait in the fifo until their update edge
  sample_type fifo_out;
  logic fifo_out_valid, fifo_pop;

  sample_fifo #(
    .WIDTH(`SPL_WORD_BITS),
    .DEPTH(`SPL_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_data(shift_q), // [RULE8]
    .in_valid(strobe_fall), // [RULE8]
    .in_ready(word_accept_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  // count rising bit clocks after the strobe falls
  update_state_type state_q, state_d;
  logic [2:0] edge_q, edge_d;
  logic [3:0] credit_q, credit_d;
  logic grant;

  always_comb begin
    state_d = state_q;
    edge_d = edge_q;
    grant = 1'b0;
    unique case (state_q)
      wait_latch: begin
        if (strobe_fall) begin
          state_d = count_edges;
          edge_d = '0;
        end
      end
      count_edges: begin
        if (strobe_fall) begin
          // a new word before the fourth edge releases the older one now
          grant = 1'b1;
          edge_d = '0;
        end else if (clk_rise) begin
          edge_d = edge_q + 3'h1;
          if (edge_d == `SPL_UPDATE_EDGE) begin
            grant = 1'b1; // [RULE9]
            state_d = wait_latch;
          end
        end
      end
    endcase
    credit_d = credit_q + {3'h0, grant} - {3'h0, fifo_pop};
  end

  assign fifo_pop = fifo_out_valid && (credit_q != 4'h0);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= wait_latch;
      edge_q <= '0;
      credit_q <= '0;
    end else begin
      state_q <= state_d;
      edge_q <= edge_d;
      credit_q <= credit_d;
    end
  end

  // split the sample into the two complementary codes
  lower_code_type lower_q, lower_d;
  upper_code_type upper_q, upper_d;
  logic update_q, update_d;
  logic neg;

  assign neg = fifo_out[`SPL_SIGN_BIT]; // [RULE1]

  always_comb begin
    lower_d = lower_q;
    upper_d = upper_q;
    update_d = fifo_pop;
    if (fifo_pop) begin
      // only one code is away from its zero value for any sample [RULE5]
      lower_d = neg ? {1'b0, fifo_out[`SPL_CODE_BITS-1:0]} // [RULE2]
                    : `SPL_LOWER_FULL; // [RULE4]
      upper_d = neg ? '0 : fifo_out[`SPL_CODE_BITS-1:0]; // [RULE3]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lower_q <= `SPL_LOWER_FULL;
      upper_q <= '0;
      update_q <= 1'b0;
    end else begin
      lower_q <= lower_d; // [RULE11]
      upper_q <= upper_d; // [RULE11]
      update_q <= update_d; // [RULE6]
    end
  end

  assign lower_code = lower_q;
  assign upper_code = upper_q;
  assign code_update = update_q;

  // checks
  property p_zero_cross;
    @(posedge ref_clk) disable iff (sys_rst)
    (lower_q == `SPL_LOWER_FULL) || (upper_q == '0);
  endproperty
  a_zero_cross: assert property (p_zero_cross) // [RULE5]
    else $error("both halves moved away from zero");

  property p_lower_neg;
    @(posedge ref_clk) disable iff (sys_rst)
    fifo_pop && neg |=> lower_q == {1'b0, $past(fifo_out[18:0])};
  endproperty
  a_lower_neg: assert property (p_lower_neg) // [RULE2]
    else $error("lower code wrong for negative sample");

  property p_upper;
    @(posedge ref_clk) disable iff (sys_rst)
    fifo_pop |=> upper_q == ($past(neg) ? '0 : $past(fifo_out[18:0]));
  endproperty
  a_upper: assert property (p_upper) // [RULE3]
    else $error("upper code wrong");

  property p_lower_pos;
    @(posedge ref_clk) disable iff (sys_rst)
    fifo_pop && !neg |=> lower_q == 20'h80000;
  endproperty
  a_lower_pos: assert property (p_lower_pos) // [RULE4]
    else $error("lower code not at full count");

  property p_shift;
    @(posedge ref_clk) disable iff (sys_rst)
    clk_rise |=> shift_q == {$past(shift_q[18:0]), $past(data_s)};
  endproperty
  a_shift: assert property (p_shift) // [RULE7]
    else $error("serial bit not captured on rising clock");

  property p_latch;
    @(posedge ref_clk) disable iff (sys_rst)
    strobe_fall && word_accept_ready && !fifo_out_valid
      |=> fifo_out_valid && fifo_out == $past(shift_q);
  endproperty
  a_latch: assert property (p_latch) // [RULE8]
    else $error("strobe fall did not latch last 20 bits");

  property p_fourth;
    @(posedge ref_clk) disable iff (sys_rst)
    state_q == count_edges && !strobe_fall && clk_rise && edge_q == 3'h3
      |-> grant;
  endproperty
  a_fourth: assert property (p_fourth) // [RULE9]
    else $error("no update on fourth clock edge");

  property p_hold;
    @(posedge ref_clk) disable iff (sys_rst)
    !update_q |-> $stable(lower_q) && $stable(upper_q);
  endproperty
  a_hold: assert property (p_hold) // [RULE11]
    else $error("codes changed without an update");

  property p_update_pulse;
    @(posedge ref_clk) disable iff (sys_rst)
    fifo_pop |=> update_q;
  endproperty
  a_update_pulse: assert property (p_update_pulse) // [RULE6]
    else $error("update pulse missing");

  // a released word must leave the fifo on the next cycle
  property p_grant_pop;
    @(posedge ref_clk) disable iff (sys_rst)
    grant |=> fifo_pop;
  endproperty
  a_grant_pop: assert property (p_grant_pop) // [RULE9]
    else $error("released word did not leave the fifo");

  property p_credit_bound;
    @(posedge ref_clk) disable iff (sys_rst)
    credit_q <= 4'h1;
  endproperty
  a_credit_bound: assert property (p_credit_bound) // [RULE11]
    else $error("more words released than waiting");

  property p_no_early;
    @(posedge ref_clk) disable iff (sys_rst)
    state_q == count_edges && !strobe_fall && edge_q < 3'h3 |-> !grant;
  endproperty
  a_no_early: assert property (p_no_early) // [RULE9]
    else $error("word released before fourth clock edge");

  property p_strobe_arm;
    @(posedge ref_clk) disable iff (sys_rst)
    strobe_fall |=> state_q == count_edges && edge_q == 3'h0;
  endproperty
  a_strobe_arm: assert property (p_strobe_arm) // [RULE9]
    else $error("strobe fall did not restart the edge count");
endmodule

// ---- rtl/splitter_pkg.sv ----
// types shared by the splitter design
package splitter_pkg;
  typedef logic [19:0] sample_type;
  typedef logic [18:0] upper_code_type;
  // one bit above 19 so the full count of 2^19 can be shown
  typedef logic [19:0] lower_code_type;
  typedef enum logic {wait_latch, count_edges} update_state_type;
endpackage

// ---- rtl/splitter_regs.svh ----
// constants for the two's complement to lower/upper code splitter
// Contract
// RULE1 - sample is 20-bit two's complement, split
// RULE2 - lower code: low 19 bits when negative
// RULE3 - upper code: low 19 bits, zero when negative
// RULE4 - lower code at full count when non-negative
// RULE5 - zero crossing changes only low bits
// RULE6 - both codes presented together
// RULE7 - msb first, one bit per rising clock
// RULE8 - strobe fall latches last 20 bits
// RULE9 - output updates on fourth rising clock; a strobe fall before that edge releases the older word at once
// RULE10 - sender holds strobe high/low one clock
// RULE11 - codes registered together from latched word
`ifndef SPLITTER_REGS_SVH
`define SPLITTER_REGS_SVH
`define SPL_WORD_BITS 20
`define SPL_CODE_BITS 19
`define SPL_SIGN_BIT 19
`define SPL_LOWER_FULL 20'h80000
`define SPL_UPDATE_EDGE 3'h4
`define SPL_FIFO_DEPTH 8
`endif

// ---- tb/audio_sender.sv ----
// serial sample sender standing in for the upstream filter
`timescale 1ns/1ps
module audio_sender (
  input wire logic ref_clk,
  output logic serial_data,
  output logic bit_clock,
  output logic word_latch_strobe
);
  initial begin
    serial_data = 1'b0;
    bit_clock = 1'b0;
    word_latch_strobe = 1'b0;
  end
  // clock stands still low between words; 125 ns period inside a word
  task automatic send(input logic [51:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge ref_clk) serial_data = b[i];
      repeat (12) @(negedge ref_clk);
      bit_clock = 1'b1;
      repeat (12) @(negedge ref_clk);
      bit_clock = 1'b0;
      // hold time over: line no longer shows the bit
      serial_data = ~b[i];
      // low kept past second clock of this word, then high
      if (i == n - 2) word_latch_strobe = 1'b1;
    end
    repeat (13) @(negedge ref_clk);
    word_latch_strobe = 1'b0;
  endtask
endmodule

// ---- tb/tb.sv ----
// bench: sender, reference queue of samples and release timing
`timescale 1ns/1ps
module tb;
  import splitter_pkg::*;
  logic ref_clk, sys_rst, sd, bc, ls, rdy, upd;
  logic bc_q = 1'b0;
  logic ls_q = 1'b0;
  lower_code_type lo;
  upper_code_type up;
  logic [19:0] w, e;
  logic [19:0] sr = 20'h0;
  logic [19:0] q[$];
  int qe[$];
  logic [19:0] tbl [9] = '{20'h7ffff, 20'h7fffe, 20'h2, 20'h1, 20'h0,
    20'hfffff, 20'hffffe, 20'h80001, 20'h80000};
  int miscompares, n_compared, seed, n_edge, ee, n_upd, n_sent;
  audio_sender u_snd (.ref_clk(ref_clk), .serial_data(sd), .bit_clock(bc),
    .word_latch_strobe(ls));
  btc_splitter u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .serial_data(sd), .bit_clock(bc), .word_latch_strobe(ls),
    .word_accept_ready(rdy), .lower_code(lo), .upper_code(up),
    .code_update(upd));
  task automatic chk(input logic [19:0] g, input logic [19:0] x);
    n_compared++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000 miscompares++;
    give_verdict;
  end
  // model word is the last 20 bits sent; the word before it is released
  // at the fourth clock, or at once when this word is shorter than that
  task automatic put(input logic [51:0] b, input int n);
    if (n_sent > 0) qe.push_back(n >= 4 ? 4 : 0);
    for (int i = n - 1; i >= 0; i--) begin
      sr = {sr[18:0], b[i]};
    end
    q.push_back(sr);
    n_sent++;
    u_snd.send(b, n);
  endtask
  // each update is checked against the oldest sample sent
  always @(negedge ref_clk) begin
    if (ls_q && !ls) n_edge = 0;
    else if (bc && !bc_q) n_edge++;
    bc_q = bc;
    ls_q = ls;
    if (upd === 1'b1) begin
      n_upd++;
      chk({19'h0, q.size() > 0 && qe.size() > 0}, 20'h1);
      e = q.size() > 0 ? q.pop_front() : 20'h0;
      ee = qe.size() > 0 ? qe.pop_front() : 0;
      chk(lo, e[19] ? {1'b0, e[18:0]} : 20'h80000);
      chk({1'b0, up}, e[19] ? 20'h0 : {1'b0, e[18:0]});
      chk(n_edge, ee);
    end
  end
  initial begin
    sys_rst = 1'b1;
    seed = 47;
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk(lo, 20'h80000);
    chk({1'b0, up}, 20'h0);
    chk({19'h0, rdy}, 20'h1);
    for (int i = 0; i < 15; i++) begin
      w = i < 9 ? tbl[i] : 20'($random(seed));
      put({$random(seed), w}, 20 + ($random(seed) & 3));
    end
    // short words: a strobe before the fourth clock releases at once
    for (int i = 0; i < 4; i++) begin
      put($random(seed), 3);
      chk({19'h0, rdy}, 20'h1);
    end
    // flush word: its clocks release the last sample
    qe.push_back(4);
    u_snd.send(52'h0, 20);
    repeat (20) @(negedge ref_clk);
    chk(q.size(), 0);
    chk(qe.size(), 0);
    chk(n_upd, n_sent);
    chk({19'h0, upd}, 20'h0);
    chk({19'h0, rdy}, 20'h1);
    give_verdict;
  end
endmodule
